// [src/rbpe_pkg.sv]
// Summary of operation
// - Single device: error two clocks after capture.
// - Pair device A: error one clock after capture.
// - Pair device B: error one clock after capture.
// - Error held low two cycles or reset.
// - Controller holds inputs low after reset release.
// - Controller keeps inputs defined after reset drop.
// - Inputs stay valid for activation time after release.
// - Second device parity fed from first's partial.
// - Reset low clears partial parity and outputs.
// - Reset low releases error output high at once.
// - Outputs update on rising clock edge, or at once when reset goes low.
// - Partial parity is registered on rising edge.
// - Error output changes launched from rising edge.
package rbpe_pkg;

    localparam int DATA_W = 25;
    localparam int PAIR_W = 14;
    localparam int OUT_W = 2 * PAIR_W;
    localparam int PAIR_B_LSB = DATA_W - PAIR_W;

    // Clock and timing
    localparam int MCLK_PERIOD_NS = 50;
    localparam int MAX_CLOCK_MHZ = 410;
    localparam int ACTIVATION_TIME_NS = 10;
    localparam int INACTIVE_TIME_NS = 15;
    localparam int ACT_CYCLES_RAW = (ACTIVATION_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int INACT_CYCLES_RAW = (INACTIVE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int ACT_CYCLES = (ACT_CYCLES_RAW < 1) ? 1 : ACT_CYCLES_RAW;
    localparam int INACT_CYCLES = (INACT_CYCLES_RAW < 1) ? 1 : INACT_CYCLES_RAW;

    // Error latency in clocks after capture, and minimum low time
    localparam int LAT_SINGLE = 2;
    localparam int LAT_PAIR = 1;
    localparam int HOLD_CYCLES = 2;

    localparam int TIMER_W = 8;
    localparam logic [TIMER_W-1:0] ACT_LOAD = TIMER_W'(ACT_CYCLES);
    localparam logic [TIMER_W-1:0] INACT_LOAD = TIMER_W'(INACT_CYCLES);
    localparam logic [1:0] HOLD_LOAD = 2'(HOLD_CYCLES - 1);

    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 25'h0000000;
    localparam logic [OUT_W-1:0] OUT_RST = 28'h0000000;
    localparam logic ERR_N_RST = 1'b1;

    // Selects the bits checked in the current width and pinout
    function automatic logic [DATA_W-1:0] rbpe_mask(input logic pair, input logic pin_b);
        logic [DATA_W-1:0] m;
        m = {DATA_W{1'b1}};
        if (pair)
        begin
            m = pin_b ? {{PAIR_W{1'b1}}, {PAIR_B_LSB{1'b0}}} : {{PAIR_B_LSB{1'b0}}, {PAIR_W{1'b1}}};
        end
        return m;
    endfunction : rbpe_mask

    // Even parity over the selected bits
    function automatic logic rbpe_parity(input logic [DATA_W-1:0] d, input logic pair,
                                         input logic pin_b);
        return ^(d & rbpe_mask(pair, pin_b));
    endfunction : rbpe_parity

endpackage : rbpe_pkg

// [src/rbpe_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rbpe_if;
    logic dev_reset_n;
    logic [rbpe_pkg::DATA_W-1:0] cmd_data;
    logic parity_in;
    logic [rbpe_pkg::OUT_W-1:0] registered_outputs;
    logic partial_parity_out;
    logic parity_error_n;

    modport dev (
        input dev_reset_n,
        input cmd_data,
        input parity_in,
        output registered_outputs,
        output partial_parity_out,
        output parity_error_n
    );

    modport ctl (
        output dev_reset_n,
        output cmd_data,
        output parity_in,
        input registered_outputs,
        input partial_parity_out,
        input parity_error_n
    );
endinterface : rbpe_if
`default_nettype wire

// [src/rbpe_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module rbpe_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [rbpe_pkg::TIMER_W-1:0] load,
    // Status
    output logic busy
);
    logic [rbpe_pkg::TIMER_W-1:0] cnt_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else if (start)
        begin
            cnt_q <= load;
        end
        else if (cnt_q != '0)
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
endmodule : rbpe_timer
`default_nettype wire

// [src/rbpe_device.sv]
`timescale 1ns/1ps
`default_nettype none
module rbpe_device (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link to the controller
    rbpe_if.dev link,
    // Straps
    input wire logic pinout_select,
    input wire logic width_select,
    // Status toward the user side
    output logic error_active
);
    // Device reset pin clears the core without a clock, like the chip's own reset
    logic clear;
    assign clear = rst | ~link.dev_reset_n;

    // Straps are board pins: two flip-flops before any logic reads them.
    // Only rst clears these, so they track the pins while the device sits in reset.
    logic [1:0] strap_meta_q;
    logic [1:0] strap_sync_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta_q <= 2'h0;
            strap_sync_q <= 2'h0;
        end
        else
        begin
            strap_meta_q <= {width_select, pinout_select};
            strap_sync_q <= strap_meta_q;
        end
    end

    logic pair_mode;
    logic pin_b;
    assign pair_mode = strap_sync_q[1];
    assign pin_b = strap_sync_q[0];

    // Captured data, kept for the parity check one clock later
    logic [rbpe_pkg::DATA_W-1:0] data_q;
    logic pair_q;
    logic pin_b_q;

    always_ff @(posedge mclk or posedge clear)
    begin
        if (clear)
        begin
            data_q <= rbpe_pkg::DATA_RST;
            pair_q <= 1'b0;
            pin_b_q <= 1'b0;
        end
        else
        begin
            data_q <= link.cmd_data;
            pair_q <= pair_mode;
            pin_b_q <= pin_b;
        end
    end

    // Fan-out of the registered outputs
    logic [rbpe_pkg::OUT_W-1:0] outputs_q;
    logic [rbpe_pkg::OUT_W-1:0] outputs_d;
    logic [rbpe_pkg::PAIR_W-1:0] half;

    always_comb
    begin
        half = pin_b ? link.cmd_data[rbpe_pkg::DATA_W-1:rbpe_pkg::PAIR_B_LSB]
                     : link.cmd_data[rbpe_pkg::PAIR_W-1:0];
        if (pair_mode)
        begin
            outputs_d = {half, half};
        end
        else
        begin
            outputs_d = {{(rbpe_pkg::OUT_W - rbpe_pkg::DATA_W){1'b0}}, link.cmd_data};
        end
    end

    always_ff @(posedge mclk or posedge clear)
    begin
        if (clear)
        begin
            outputs_q <= rbpe_pkg::OUT_RST;
        end
        else
        begin
            outputs_q <= outputs_d;
        end
    end

    assign link.registered_outputs = outputs_q;

    // Parity of the data captured last edge against the parity that follows it
    logic mismatch;
    assign mismatch = rbpe_pkg::rbpe_parity(data_q, pair_q, pin_b_q) ^ link.parity_in;

    logic ppo_q;
    logic mismatch_q;

    always_ff @(posedge mclk or posedge clear)
    begin
        if (clear)
        begin
            ppo_q <= 1'b0;
            mismatch_q <= 1'b0;
        end
        else
        begin
            ppo_q <= mismatch;
            mismatch_q <= mismatch;
        end
    end

    assign link.partial_parity_out = ppo_q;

    // Pair mode launches the error one clock after capture, single mode two
    logic err_set;
    assign err_set = pair_q ? mismatch : mismatch_q;

    // Error output hold: low for at least two clocks, extended by a fresh error
    typedef enum logic [1:0]
    {
        RBPE_OK = 2'b00,
        RBPE_LOW = 2'b01
    } rbpe_err_t;

    rbpe_err_t err_state_q;
    logic [1:0] hold_q;

    always_ff @(posedge mclk or posedge clear)
    begin
        if (clear)
        begin
            err_state_q <= RBPE_OK;
            hold_q <= 2'h0;
        end
        else
        begin
            unique case (err_state_q)
                RBPE_OK:
                begin
                    if (err_set)
                    begin
                        err_state_q <= RBPE_LOW;
                        hold_q <= rbpe_pkg::HOLD_LOAD;
                    end
                end
                RBPE_LOW:
                begin
                    if (err_set)
                    begin
                        hold_q <= rbpe_pkg::HOLD_LOAD;
                    end
                    else if (hold_q != 2'h0)
                    begin
                        hold_q <= hold_q - 2'h1;
                    end
                    else
                    begin
                        err_state_q <= RBPE_OK;
                    end
                end
                default:
                begin
                    err_state_q <= RBPE_OK;
                end
            endcase
        end
    end

    // Hold has run out; a fresh error in the same cycle still wins
    logic err_release;
    assign err_release = (err_state_q == RBPE_LOW) && (hold_q == 2'h0);

    // Output taken straight from a register, so no decode glitch
    logic err_n_q;

    always_ff @(posedge mclk or posedge clear)
    begin
        if (clear)
        begin
            err_n_q <= rbpe_pkg::ERR_N_RST;
        end
        else if (err_set)
        begin
            err_n_q <= 1'b0;
        end
        else if (err_release)
        begin
            err_n_q <= 1'b1;
        end
    end

    assign link.parity_error_n = err_n_q;

    // User-side copy kept in its own flip-flop, in step with the pin
    always_ff @(posedge mclk or posedge clear)
    begin
        if (clear)
        begin
            error_active <= 1'b0;
        end
        else if (err_set)
        begin
            error_active <= 1'b1;
        end
        else if (err_release)
        begin
            error_active <= 1'b0;
        end
    end
endmodule : rbpe_device
`default_nettype wire

// [src/rbpe_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rbpe_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link to the buffer
    rbpe_if.ctl link,
    // User control
    input wire logic run,
    input wire logic pair_mode,
    input wire logic pinout_b,
    input wire logic force_bad_parity,
    // User command stream
    input wire logic cmd_valid,
    input wire logic [rbpe_pkg::DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    // Status
    output logic link_up,
    output logic error_seen
);
    logic reset_n_q;
    logic timer_busy;
    logic release_now;
    logic drop_now;
    logic [rbpe_pkg::TIMER_W-1:0] timer_load;

    assign release_now = run & ~reset_n_q & ~timer_busy;
    assign drop_now = ~run & reset_n_q & ~timer_busy;
    assign timer_load = release_now ? rbpe_pkg::ACT_LOAD : rbpe_pkg::INACT_LOAD;

    // One timer covers both the activation quiet time and the inactive hold
    rbpe_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .start(release_now | drop_now),
        .load(timer_load),
        .busy(timer_busy)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reset_n_q <= 1'b0;
        end
        else if (release_now)
        begin
            reset_n_q <= 1'b1;
        end
        else if (drop_now)
        begin
            reset_n_q <= 1'b0;
        end
    end

    // No command until the activation time has passed
    assign cmd_ready = reset_n_q & ~timer_busy & run;
    logic fire;
    assign fire = cmd_valid & cmd_ready;

    logic [rbpe_pkg::DATA_W-1:0] data_q;
    logic fire_q;
    logic bad_q;
    logic par_q;

    // Idle inputs are driven low, never left floating
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            data_q <= rbpe_pkg::DATA_RST;
            fire_q <= 1'b0;
            bad_q <= 1'b0;
            par_q <= 1'b0;
        end
        else
        begin
            data_q <= fire ? cmd_data : rbpe_pkg::DATA_RST;
            fire_q <= fire;
            bad_q <= fire & force_bad_parity;
            // Parity trails its data by one clock
            par_q <= fire_q & (rbpe_pkg::rbpe_parity(data_q, pair_mode, pinout_b) ^ bad_q);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            error_seen <= 1'b0;
        end
        else
        begin
            error_seen <= reset_n_q & ~link.parity_error_n;
        end
    end

    assign link.dev_reset_n = reset_n_q;
    assign link.cmd_data = data_q;
    assign link.parity_in = par_q;
    assign link_up = cmd_ready;
endmodule : rbpe_host
`default_nettype wire

// [test/rbpe_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module rbpe_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link
    input wire logic dev_reset_n,
    input wire logic [rbpe_pkg::DATA_W-1:0] cmd_data,
    input wire logic parity_in,
    input wire logic [rbpe_pkg::OUT_W-1:0] registered_outputs,
    input wire logic partial_parity_out,
    input wire logic parity_error_n,
    // Straps
    input wire logic width_select,
    input wire logic pinout_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    function automatic logic [13:0] half(input logic [24:0] d, input logic b);
        return b ? d[24:11] : d[13:0];
    endfunction : half

    function automatic logic [27:0] image(input logic [24:0] d, input logic w, input logic b);
        return w ? {2{half(d, b)}} : {3'h0, d};
    endfunction : image

    function automatic logic par(input logic [24:0] d, input logic w, input logic b);
        return w ? ^half(d, b) : ^d;
    endfunction : par

    property p_out_image;
        $past(dev_reset_n) && dev_reset_n |->
            registered_outputs == image($past(cmd_data), width_select, pinout_select);
    endproperty
    a_out_image: assert property (p_out_image) else $error("outputs differ from word");

    property p_ppo;
        $past(dev_reset_n, 2) && $past(dev_reset_n) && dev_reset_n |-> partial_parity_out ==
            (par($past(cmd_data, 2), width_select, pinout_select) ^ $past(parity_in));
    endproperty
    a_ppo: assert property (p_ppo) else $error("partial parity wrong");

    property p_err_pair;
        width_select && partial_parity_out |-> !parity_error_n;
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("pair error late");

    property p_err_single;
        !width_select && partial_parity_out |=> !parity_error_n || !dev_reset_n;
    endproperty
    a_err_single: assert property (p_err_single) else $error("single error late");

    property p_err_hold;
        $fell(parity_error_n) |=> !parity_error_n || !dev_reset_n;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error too short");

    property p_err_cause;
        $fell(parity_error_n) |->
            (width_select ? partial_parity_out : $past(partial_parity_out));
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error without cause");

    property p_clear;
        !dev_reset_n |-> registered_outputs == 28'h0 && !partial_parity_out;
    endproperty
    a_clear: assert property (p_clear) else $error("outputs not cleared");

    property p_release;
        !dev_reset_n |-> parity_error_n;
    endproperty
    a_release: assert property (p_release) else $error("error not released");

    c_pair: cover property (width_select && $fell(parity_error_n));
    c_single: cover property (!width_select && $fell(parity_error_n));
    c_cut: cover property (!parity_error_n ##1 !dev_reset_n);
endmodule : rbpe_assertions
`default_nettype wire

// [test/registered_buffer_parity_error_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module registered_buffer_parity_error_test;
    logic mclk, rst, run, pair, pin_b, bad, cmd_valid, cmd_ready, error_active;
    logic link_up, error_seen;
    logic [24:0] cmd_data;
    int n_mismatch, checks_done, cycles;
    logic [24:0] words [4] = '{25'h1ffffff, 25'h0000001, 25'h0aaaaaa, 25'h1555555};

    rbpe_if link();
    rbpe_host i_rbpe_host (.mclk(mclk), .rst(rst), .link(link.ctl), .run(run),
        .pair_mode(pair), .pinout_b(pin_b), .force_bad_parity(bad), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .link_up(link_up),
        .error_seen(error_seen));
    rbpe_device i_rbpe_device (.mclk(mclk), .rst(rst), .link(link.dev),
        .pinout_select(pin_b), .width_select(pair), .error_active(error_active));
    rbpe_assertions i_rbpe_assertions (.mclk(mclk), .rst(rst),
        .dev_reset_n(link.dev_reset_n), .cmd_data(link.cmd_data), .parity_in(link.parity_in),
        .registered_outputs(link.registered_outputs), .parity_error_n(link.parity_error_n),
        .partial_parity_out(link.partial_parity_out), .width_select(pair),
        .pinout_select(pin_b));

    task automatic complete_run;
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // One command, then watch the error output until its hold has run out
    task automatic send(input logic [24:0] d, input logic b);
        logic [27:0] img;
        int lat;
        int n;
        img = pair ? {2{pin_b ? d[24:11] : d[13:0]}} : {3'h0, d};
        lat = pair ? 1 : 2;
        n = 0;
        cmd_valid = 1'b1;
        cmd_data = d;
        bad = b;
        while (cmd_ready !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        `CHK("ready", 1'b1, cmd_ready)
        `CHK("link_up", 1'b1, link_up)
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_data = 25'h0;
        bad = 1'b0;
        @(negedge mclk);
        `CHK("outputs", img, link.registered_outputs)
        for (int i = 2; i <= 5; i++)
        begin
            @(negedge mclk);
            `CHK("error_n", !(b && i >= lat + 1 && i <= lat + 2), link.parity_error_n)
            `CHK("error_active", b && i >= lat + 1 && i <= lat + 2, error_active)
            `CHK("error_seen", b && i >= lat + 2 && i <= lat + 3, error_seen)
            // Partial parity is what a second device's parity input is fed from
            `CHK("ppo", b && i == 2, link.partial_parity_out)
        end
    endtask : send

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        {rst, run, pair, pin_b, bad, cmd_valid, cmd_data} = {6'h20, 25'h0};
        repeat (12) @(negedge mclk);
        `CHK("reset outputs", 28'h0, link.registered_outputs)
        `CHK("reset error_n", 1'b1, link.parity_error_n)
        rst = 1'b0;
        run = 1'b1;
        foreach (words[k]) send(words[k], k[0]);
        for (int m = 0; m < 2; m++)
        begin
            // Straps change only while the device is held in reset
            run = 1'b0;
            repeat (3) @(negedge mclk);
            pair = 1'b1;
            pin_b = m[0];
            run = 1'b1;
            foreach (words[k]) send(words[k], k[0]);
        end
        // Back-to-back bad words, then reset drop while the error is low
        cmd_valid = 1'b1;
        cmd_data = 25'h1ffffff;
        bad = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("error_n held", 1'b0, link.parity_error_n)
        run = 1'b0;
        @(negedge mclk);
        `CHK("cut outputs", 28'h0, link.registered_outputs)
        `CHK("cut ppo", 1'b0, link.partial_parity_out)
        `CHK("cut error_n", 1'b1, link.parity_error_n)
        cmd_valid = 1'b0;
        bad = 1'b0;
        repeat (2) @(negedge mclk);
        complete_run();
    end
endmodule : registered_buffer_parity_error_test
`default_nettype wire
